//--- logic/epse_core.sv
// power-on-reset state, status bits, output release and ecc read path
`timescale 1ns/1ps
`include "epse_defines.svh"
// Behaviour
// - ignore instructions before supply crosses threshold
// - reset clears the write permit latch
// - reset clears the write ongoing flag
// - reset keeps lock and block protect bits
// - reset leaves standby, deselected, not held
// - supply drop resets and locks out instructions
// - output released from the first edge after deselect
// - single bit error per byte corrected on read
// - correction invisible to protocol timing
// - delivered array reads all ones
// - delivered lock and protect bits are zero
// - delivered id page holds three id bytes
module epse_core
	import epse_pkg::*;
#(
	parameter logic [23:0] DEVICE_ID = 24'h5a_a5_3c, // arbitrary value
	parameter int WRITE_CYC = `EPSE_WRITE_CYC
)
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic power_good,
	input wire logic select_n,
	input wire logic hold_n,
	input wire logic cmd_valid,
	input wire logic cmd_is_read,
	input wire logic cmd_is_id,
	input wire logic cmd_set_wpl,
	input wire logic cmd_clr_wpl,
	input wire logic cmd_write,
	input wire logic cmd_write_status,
	input wire logic [9:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	input wire logic fault_inject,
	input wire logic [3:0] fault_pos,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic rd_corrected,
	output logic sdo_oe_n,
	output logic [7:0] status_byte,
	output logic device_ready,
	output logic standby,
	output logic held
);
	// *****************************************
	// power monitor release
	// *****************************************
	logic [1:0] pg_sync;
	logic por;
	// async assert, release through two flops on mclk
	always_ff @(posedge mclk or negedge power_good) begin
		if (!power_good) begin
			pg_sync <= 2'b00;
		end else begin
			pg_sync <= {pg_sync[0], 1'b1};
		end
	end
	// power drop acts at once, release only after sync
	assign por = rst | ~pg_sync[1];

	// *****************************************
	// storage
	// *****************************************
	epse_code_t mem [0:1023];
	logic [7:0] id_page [0:31];
	logic [1:0] bp;
	logic swl;
	logic wpl;
	logic wof;
	// delivery contents load once, at the first edge after power-up
	logic delivered = 1'b0;
	epse_state_t state;
	epse_state_t next_state;
	logic [15:0] wcount;

	function automatic epse_code_t epse_encode(input logic [7:0] d);
		epse_code_t c;
		c = 12'h000;
		c[2] = d[0];
		c[4] = d[1];
		c[5] = d[2];
		c[6] = d[3];
		c[8] = d[4];
		c[9] = d[5];
		c[10] = d[6];
		c[11] = d[7];
		c[0] = ^(c & 12'h554);
		c[1] = ^(c & 12'h664);
		c[3] = ^(c & 12'h870);
		c[7] = ^(c & 12'hf00);
		return c;
	endfunction

	// *****************************************
	// decode
	// *****************************************
	wire accept;
	wire is_id_rd;
	wire do_write;
	wire do_sr;
	wire [1:0] sel_prot;
	wire prot_hit;
	// instructions only while powered, selected, not held, idle
	assign accept = cmd_valid & ~por & ~select_n & hold_n & (state == EPSE_ACTIVE);
	assign sel_prot = bp;
	assign prot_hit = (sel_prot == 2'b11) |
		((sel_prot == 2'b10) & cmd_addr[9]) |
		((sel_prot == 2'b01) & (cmd_addr[9:8] == 2'b11));
	assign is_id_rd = accept & cmd_is_read & cmd_is_id;
	assign do_write = accept & cmd_write & wpl & ~prot_hit & ~cmd_is_id;
	assign do_sr = accept & cmd_write_status & wpl;

	// state: off only under reset, standby when deselected outside a write
	always_comb begin
		next_state = state;
		unique case (state)
			EPSE_OFF: next_state = EPSE_STANDBY;
			EPSE_STANDBY: if (!select_n) next_state = EPSE_ACTIVE;
			EPSE_ACTIVE: begin
				if (do_write | do_sr) next_state = EPSE_WRITING;
				else if (select_n) next_state = EPSE_STANDBY;
			end
			EPSE_WRITING: if (wcount == 16'h0000) next_state = EPSE_STANDBY;
		endcase
	end

	// *****************************************
	// volatile status and state
	// *****************************************
	always_ff @(posedge mclk or negedge power_good) begin
		if (!power_good) begin
			state <= EPSE_OFF;
			wpl <= 1'b0;
			wof <= 1'b0;
			wcount <= 16'h0000;
		end else if (por) begin
			state <= EPSE_OFF;
			wpl <= 1'b0;
			wof <= 1'b0;
			wcount <= 16'h0000;
		end else begin
			state <= next_state;
			if (do_write | do_sr) begin
				wpl <= 1'b0;
				wof <= 1'b1;
				wcount <= 16'(WRITE_CYC - 1);
			end else if (state == EPSE_WRITING) begin
				wof <= (wcount != 16'h0000);
				wcount <= (wcount == 16'h0000) ? 16'h0000 : wcount - 16'h0001;
			end else if (accept & cmd_set_wpl) begin
				wpl <= 1'b1;
			end else if (accept & cmd_clr_wpl) begin
				wpl <= 1'b0;
			end
		end
	end

	// *****************************************
	// non-volatile contents
	// *****************************************
	// no reset branch: supply reset never touches these
	always_ff @(posedge mclk) begin
		if (!delivered) begin
			delivered <= 1'b1;
			swl <= 1'b0;
			bp <= 2'b00;
			for (int i = 0; i < 1024; i++) begin
				mem[i] <= epse_encode(`EPSE_ERASED_BYTE);
			end
			for (int j = 0; j < 32; j++) begin
				id_page[j] <= (j < `EPSE_ID_BYTES) ?
					DEVICE_ID[8'(23 - 8 * j) -: 8] : 8'h00;
			end
		end else if (do_sr & ~swl) begin
			swl <= cmd_wdata[`EPSE_SR_SWL];
			bp <= {cmd_wdata[`EPSE_SR_BPH], cmd_wdata[`EPSE_SR_BPL]};
		end else if (do_write) begin
			mem[cmd_addr] <= epse_encode(cmd_wdata);
		end else if (fault_inject & ~accept) begin
			mem[cmd_addr] <= mem[cmd_addr] ^ (12'h001 << fault_pos);
		end
	end

	// *****************************************
	// read path
	// *****************************************
	epse_ecc_if ecc_bus ();
	assign ecc_bus.code = mem[cmd_addr];
	epse_ecc u_ecc (.port_c(ecc_bus));

	// same one-cycle latency with or without a fix
	always_ff @(posedge mclk) begin
		if (por) begin
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
			rd_corrected <= 1'b0;
			sdo_oe_n <= 1'b1;
			status_byte <= {swl, 3'b000, bp, 2'b00};
			device_ready <= 1'b0;
			standby <= 1'b1;
			held <= 1'b0;
		end else begin
			rd_valid <= accept & cmd_is_read;
			rd_data <= is_id_rd ? id_page[cmd_addr[4:0]] : ecc_bus.data;
			rd_corrected <= accept & cmd_is_read & ~cmd_is_id & ecc_bus.fixed;
			sdo_oe_n <= select_n | ~hold_n;
			status_byte <= {swl, 3'b000, bp, wpl, wof};
			device_ready <= 1'b1;
			standby <= (next_state != EPSE_ACTIVE);
			held <= ~select_n & ~hold_n;
		end
	end
endmodule

//--- logic/epse_defines.svh
// constants for the eeprom power-on-reset state and ecc block
`ifndef EPSE_DEFINES_SVH
`define EPSE_DEFINES_SVH
`define EPSE_DATA_W 8
`define EPSE_CHECK_W 4
`define EPSE_CODE_W 12
`define EPSE_ADDR_W 10
`define EPSE_ID_ADDR_W 5
`define EPSE_ERASED_BYTE 8'hff
`define EPSE_SR_WPL 1
`define EPSE_SR_WOF 0
`define EPSE_SR_BPL 2
`define EPSE_SR_BPH 3
`define EPSE_SR_SWL 7
`define EPSE_ID_BYTES 3
`define EPSE_SYNC_STAGES 2
`define EPSE_WRITE_TIME_US 4
`define EPSE_CLK_MHZ 25
`define EPSE_WRITE_CYC (`EPSE_WRITE_TIME_US * `EPSE_CLK_MHZ)
`endif

//--- logic/epse_ecc.sv
// single-error-correcting decoder for one stored byte
`timescale 1ns/1ps
`include "epse_defines.svh"
module epse_ecc
	import epse_pkg::*;
(
	epse_ecc_if.corrector port_c
);
	// *****************************************
	// syndrome and correction
	// *****************************************
	// hamming(12,8): position p (1..12) holds check bits at 1,2,4,8
	wire [3:0] syndrome;
	wire [11:0] flipped;
	assign syndrome[0] = ^(port_c.code & 12'h555);
	assign syndrome[1] = ^(port_c.code & 12'h666);
	assign syndrome[2] = ^(port_c.code & 12'h878);
	assign syndrome[3] = ^(port_c.code & 12'hf80);
	// one bad bit is put back; the byte stays unchanged when syndrome is zero
	assign flipped = (syndrome == 4'h0) ? port_c.code :
		(port_c.code ^ (12'h001 << (syndrome - 4'h1)));
	assign port_c.data = {flipped[11:8], flipped[6:4], flipped[2]};
	assign port_c.fixed = (syndrome != 4'h0);
endmodule

//--- logic/epse_ecc_if.sv
// interface carrying a stored codeword to the byte corrector and the result back
`timescale 1ns/1ps
interface epse_ecc_if;
	logic [11:0] code;
	logic [7:0] data;
	logic fixed;
	modport user (output code, input data, input fixed);
	modport corrector (input code, output data, output fixed);
endinterface

//--- logic/epse_pkg.sv
// types shared by the eeprom power-on-reset state and ecc block
package epse_pkg;
	typedef enum logic [1:0] {
		EPSE_OFF = 2'b00,
		EPSE_STANDBY = 2'b01,
		EPSE_ACTIVE = 2'b11,
		EPSE_WRITING = 2'b10
	} epse_state_t;
	typedef logic [11:0] epse_code_t;
endpackage

//--- tb/epse_core_properties.sv
// concurrent checks on the ports of the power-on-reset state and ecc block
`timescale 1ns/1ps
module epse_core_properties (
	input wire logic mclk,
	input wire logic rst,
	input wire logic power_good,
	input wire logic select_n,
	input wire logic cmd_valid,
	input wire logic cmd_is_read,
	input wire logic cmd_is_id,
	input wire logic rd_valid,
	input wire logic rd_corrected,
	input wire logic sdo_oe_n,
	input wire logic [7:0] status_byte,
	input wire logic standby,
	input wire logic held
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// ****************************************
	// output release, reset state, read path
	// ****************************************
	oe_release_a: assert property (select_n && $past(select_n) |-> sdo_oe_n)
		else $error("output driven while deselected");
	hold_release_a: assert property (held |-> sdo_oe_n)
		else $error("output driven while held");
	reset_state_a: assert property ($fell(rst) |-> standby && !held && sdo_oe_n)
		else $error("wrong mode after reset");
	reset_clear_a: assert property ($fell(rst) |-> status_byte[1:0] == 2'b00)
		else $error("volatile status bits kept over reset");
	power_keep_a: assert property (!power_good |=> status_byte[7:2] == $past(status_byte[7:2]))
		else $error("protection bits changed by supply reset");
	power_clear_a: assert property (!power_good && $past(!power_good) |-> status_byte[1:0] == 2'b00)
		else $error("volatile status bits kept at low supply");
	power_lock_a: assert property (!power_good && $past(!power_good) |-> !rd_valid)
		else $error("read answered at low supply");
	read_answer_a: assert property (rd_valid |->
		$past(cmd_valid && (cmd_is_read || cmd_is_id) && !select_n))
		else $error("read data without a read one cycle before");
	fix_flag_a: assert property (rd_corrected |-> rd_valid)
		else $error("correction flag outside a read");
endmodule
bind epse_core epse_core_properties chk_i (.*);

//--- tb/epse_core_tb_top.sv
// self-checking bench for the power-on-reset state and ecc block
`timescale 1ns/1ps
module epse_core_tb_top;
	import epse_pkg::*;
	localparam logic [23:0] ID = 24'h12_34_56; // arbitrary value
	localparam logic [5:0] RD = 6'h20, IDR = 6'h30, SW = 6'h08, WR = 6'h02, WS = 6'h01;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic power_good = 1'b1;
	logic fault_inject = 1'b0;
	logic [3:0] fault_pos = 4'h5;
	logic select_n, hold_n, cmd_valid, rd_valid, rd_corrected, sdo_oe_n, standby, held;
	logic device_ready;
	logic [5:0] kind;
	logic [9:0] cmd_addr;
	logic [7:0] cmd_wdata, rd_data, status_byte;
	int fail_count = 0;
	int n_compared = 0;
	always #20 mclk = ~mclk;
	epse_master_model m (.mclk(mclk), .select_n(select_n), .hold_n(hold_n),
		.cmd_valid(cmd_valid), .kind(kind), .addr(cmd_addr), .wdata(cmd_wdata));
	epse_core #(.DEVICE_ID(ID), .WRITE_CYC(4)) DUT (.*, .cmd_is_read(kind[5]),
		.cmd_is_id(kind[4]), .cmd_set_wpl(kind[3]), .cmd_clr_wpl(kind[2]),
		.cmd_write(kind[1]), .cmd_write_status(kind[0]), .device_ready(device_ready));
	task report_and_stop;
		$display("compared %0d, wrong %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// read answered one cycle after it is taken, or refused
	task rd(input logic [5:0] k, input logic [9:0] a, input logic [7:0] e, input logic v);
		m.op(k, a, 8'h00);
		chk({7'h00, rd_valid}, {7'h00, v});
		if (v) chk(rd_data, e);
	endtask
	// status lags the write by one edge, so look only after it shows busy
	task wait_wr;
		cyc(1);
		for (int i = 0; i < 40 && status_byte[0] !== 1'b0; i++) cyc(1);
		if (status_byte[0] !== 1'b0) begin
			fail_count++;
			$display("wrong value at %0t: write cycle never ended", $time);
		end
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		cyc(12);
		rst = 1'b0;
		chk(status_byte, 8'h00);
		chk({4'h0, device_ready, sdo_oe_n, standby, held}, 8'h06);
		m.sel(1'b0, 1'b1);
		cyc(2);
		for (int a = 0; a < 1024; a += 341) rd(RD, a[9:0], 8'hff, 1'b1);
		for (int i = 0; i < 3; i++) rd(IDR, i[9:0], ID[23 - 8 * i -: 8], 1'b1);
		$display("delivery test done");
		m.op(SW, 10'h000, 8'h00);
		m.op(WR, 10'h005, 8'h3c);
		wait_wr;
		fault_inject = 1'b1;
		cyc(1);
		fault_inject = 1'b0;
		rd(RD, 10'h005, 8'h3c, 1'b1);
		chk({7'h00, rd_corrected}, 8'h01);
		m.op(SW, 10'h000, 8'h00);
		m.op(WS, 10'h000, 8'h8c);
		wait_wr;
		chk(status_byte, 8'h8c);
		m.sel(1'b0, 1'b0);
		rd(RD, 10'h005, 8'h00, 1'b0);
		chk({7'h00, sdo_oe_n}, 8'h01);
		m.sel(1'b1, 1'b1);
		rd(RD, 10'h005, 8'h00, 1'b0);
		$display("ecc and release test done");
		m.sel(1'b0, 1'b1);
		m.op(SW, 10'h000, 8'h00);
		m.sel(1'b1, 1'b1); // deselected, no write running
		power_good = 1'b0;
		cyc(3);
		chk(status_byte, 8'h8c);
		chk({7'h00, device_ready}, 8'h00);
		m.sel(1'b0, 1'b1);
		rd(RD, 10'h005, 8'h00, 1'b0);
		m.sel(1'b1, 1'b1);
		power_good = 1'b1;
		cyc(4);
		chk({4'h0, device_ready, sdo_oe_n, standby, held}, 8'h0e);
		m.sel(1'b0, 1'b1);
		cyc(2);
		rd(RD, 10'h005, 8'h3c, 1'b1);
		$display("supply test done");
		report_and_stop;
	end
	// watchdog at 2500 cycles, well beyond the fewer than one hundred cycles the sequence needs
	initial begin
		#100000;
		fail_count++;
		report_and_stop;
	end
endmodule

//--- tb/epse_master_model.sv
// command-level bus master driving the memory's decoded instruction inputs
`timescale 1ns/1ps
module epse_master_model (
	input wire logic mclk,
	output logic select_n,
	output logic hold_n,
	output logic cmd_valid,
	output logic [5:0] kind,
	output logic [9:0] addr,
	output logic [7:0] wdata
);
	// select idles high from time zero, never left floating
	initial begin
		select_n = 1'b1;
		hold_n = 1'b1;
		cmd_valid = 1'b0;
		kind = 6'h00;
		addr = 10'h000;
		wdata = 8'h00;
	end
	// only this one device is ever selected on the bus
	task sel(input logic s, input logic h);
		@(posedge mclk);
		#1 select_n = s;
		hold_n = h;
	endtask
	// one instruction, strobe held over exactly one edge
	task op(input logic [5:0] k, input logic [9:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1 cmd_valid = 1'b1;
		kind = k;
		addr = a;
		wdata = d;
		@(posedge mclk);
		#1 cmd_valid = 1'b0;
		kind = ~k; // released qualifiers do not keep their value
	endtask
endmodule
